// ### bench/pcls_props.sv
// Checker on the host-device link: reply timing, pairing and station.
// Assumes one clock, sync active-high reset, instantiated beside the link.
`timescale 1ns/1ps
module pcls_props
    import pcls_pkg::*;
#(
    parameter int MS_CYC = MS_TICK_CYC
)
(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       cmd_valid,
    input wire logic [6:0] cmd_station,
    input wire logic       cmd_sw_reset,
    input wire logic       rsp_valid,
    input wire logic [6:0] rsp_station
);
    localparam int RSP_MAX = WAIT_MAX_MS * MS_CYC + 3;
    logic [127:0] seen;
    logic         pend;
    logic         hit;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Frame for the station already seen in a reply; station 0 means none known yet
    assign hit = cmd_valid && (cmd_station == rsp_station) && (rsp_station != 7'h00);
    // Stations framed since the last reply; a frame in the reply cycle starts afresh
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seen <= '0;
        end else begin
            seen <= (rsp_valid ? '0 : seen) | (cmd_valid ? (128'h1 << cmd_station) : '0);
        end
    end
    // One reply outstanding; frames in the reply cycle are not tracked
    always_ff @(posedge mclk) begin
        pend <= !sys_rst && !rsp_valid && (pend || hit);
    end
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("reply strobe longer than one cycle");
    AST_STN_HOLD: assert property (!rsp_valid |-> $stable(rsp_station))
        else $error("reply station moved without a reply");
    AST_HAS_CAUSE: assert property (rsp_valid |-> seen[rsp_station])
        else $error("reply without a frame for that station");
    AST_REPLY_WITHIN: assert property (hit && !pend |-> ##[2:RSP_MAX] rsp_valid)
        else $error("matching frame got no reply in time");
    AST_NOT_NEXT: assert property (hit && !pend |=> !rsp_valid)
        else $error("reply came the cycle after its frame");
    AST_RST_FRAME: assert property (cmd_sw_reset |-> cmd_valid)
        else $error("reset flag without a frame");
    AST_STN_RANGE: assert property (rsp_valid |-> rsp_station inside {[STN_MIN:STN_MAX]})
        else $error("reply station out of range");
    AST_QUIET_START: assert property ($fell(sys_rst) |-> !rsp_valid [*2])
        else $error("reply right after reset");
    COV_REPLY: cover property (rsp_valid);
    COV_SW_RESET: cover property (cmd_valid && cmd_sw_reset);
    COV_OTHER_STN: cover property (cmd_valid && cmd_station != rsp_station);
endmodule : pcls_props

// ### bench/testbench.sv
// Bench for the panel unit: host and device ends joined by one link.
// Assumes package, link and both ends are compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    import pcls_pkg::*;
    localparam int LONG = 30;
    localparam int SHORT = 10;
    localparam int MSC = 4;
    logic       mclk = 1'b0, sys_rst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0;
    logic [1:0] sw_addr = 2'h0;
    logic [7:0] sw_wdata = 8'h00, sw_rdata;
    logic [4:0] keys = 5'h00; // Tier, ref, aux, mode, up
    logic [6:0] station_sw = 7'h05, station;
    logic       port_sel = 1'b0, adc_err = 1'b0, auto_scroll = 1'b0, op_stopped = 1'b0;
    logic       reg_done = 1'b0, reg_ok = 1'b0, reg_active = 1'b0;
    logic [3:0] menu_tier_display, data_bits;
    logic       fast_blink, reg_start, reg_cancel, alarm_release, alarm_lamp_off;
    logic       param_init, por_pulse, parity1, parity2, pending_defaults;
    logic [1:0] reg_lamp, stop_bits1, stop_bits2;
    logic [2:0] baud1, baud2;
    int         n_mismatch = 0, samples_checked = 0, cyc = 0;
    int         pc[6] = '{default: 0};
    pcls_if lnk_if ();
    pcls_host pcls_host_inst (.mclk, .sys_rst, .lnk(lnk_if), .sw_addr, .sw_wdata, .sw_wr,
        .sw_rd, .sw_rdata);
    pcls_dev #(.HOLD_LONG_CYC(LONG), .HOLD_SHORT_CYC(SHORT), .MS_CYC(MSC)) pcls_dev_inst (
        .mclk, .sys_rst, .lnk(lnk_if), .tier_key(keys[0]), .ref_key(keys[1]),
        .aux_command_key(keys[2]), .mode_key(keys[3]), .up_key(keys[4]), .station_sw,
        .port_sel, .adc_err, .auto_scroll, .op_stopped, .reg_done, .reg_ok, .reg_active,
        .menu_tier_display, .fast_blink, .reg_start, .reg_cancel, .alarm_release,
        .alarm_lamp_off, .param_init, .por_pulse, .reg_lamp, .baud1, .baud2, .parity1,
        .parity2, .stop_bits1, .stop_bits2, .data_bits, .station, .pending_defaults);
    pcls_props #(.MS_CYC(MSC)) pcls_props_inst (.mclk, .sys_rst,
        .cmd_valid(lnk_if.cmd_valid), .cmd_station(lnk_if.cmd_station),
        .cmd_sw_reset(lnk_if.cmd_sw_reset), .rsp_valid(lnk_if.rsp_valid),
        .rsp_station(lnk_if.rsp_station));
    always #4 mclk = ~mclk;
    // Pulse tallies; the 6000-cycle ceiling sits well above the roughly 800 cycles needed
    always @(posedge mclk) begin
        cyc++;
        pc[0] += int'(reg_start === 1'b1);
        pc[1] += int'(reg_cancel === 1'b1);
        pc[2] += int'(alarm_release === 1'b1);
        pc[3] += int'(alarm_lamp_off === 1'b1);
        pc[4] += int'(param_init === 1'b1);
        pc[5] += int'(por_pulse === 1'b1);
        if (cyc == 6000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        tick(1);
        sw_wr <= 1'b0;
    endtask : sw_write
    // Read data appears in the cycle after the strobe and holds until the next read
    task automatic sw_read(input logic [1:0] a, output logic [7:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        tick(1);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
        tick(1);
    endtask : sw_read
    task automatic press(input logic [4:0] k, input int n);
        keys <= k;
        tick(n);
        keys <= 5'h00;
        tick(4);
    endtask : press
    task automatic t_defaults();
        `CHK("baud1", 3'(BAUD_DEF), baud1)
        `CHK("baud2", 3'h4, baud2)
        `CHK("parity2", PARITY_DEF, parity2)
        `CHK("stop1", 2'h1, stop_bits1)
        `CHK("stop2", 2'h1, stop_bits2)
        `CHK("parity1", 1'b1, parity1)
        `CHK("data bits", 4'h8, data_bits)
        `CHK("station", 7'h05, station)
        $display("t_defaults done");
    endtask : t_defaults
    task automatic t_link();
        logic [7:0] d;
        int         n;
        for (int p = 0; p < 2; p++) begin
            port_sel <= p[0];
            sw_write(2'h0, 8'h05);
            n = 0;
            while (lnk_if.rsp_valid !== 1'b1 && n < 500) begin
                @(posedge mclk);
                #1 n++;
            end
            tick(1);
            `CHK("reply delay", 1'b1, (n >= 80 && n <= 88))
            sw_read(2'h2, d);
            `CHK("reply station", 8'h05, d)
        end
        station_sw <= 7'h09;
        sw_write(2'h0, 8'h09);
        tick(120);
        sw_read(2'h1, d);
        `CHK("reply count", 8'h02, d)
        `CHK("station kept", 7'h05, station)
        sw_read(2'h3, d);
        `CHK("unmapped", 8'h00, d)
        station_sw <= 7'h05;
        port_sel <= 1'b0;
        $display("t_link done");
    endtask : t_link
    task automatic t_tiers();
        press(5'h01, LONG + 2);
        `CHK("tier init", 4'h0, menu_tier_display)
        press(5'h01, 2);
        `CHK("tier port1", 4'h1, menu_tier_display)
        press(5'h10, 1);
        `CHK("baud step", 3'h5, baud1)
        press(5'h18, 1);
        `CHK("parity none", 1'b0, parity1)
        `CHK("two stops", 2'h2, stop_bits1)
        press(5'h01, 2);
        `CHK("tier port2", 4'h2, menu_tier_display)
        press(5'h01, SHORT + 2);
        `CHK("tier back", 4'hF, menu_tier_display)
        press(5'h01, LONG + 2);
        press(5'h0C, LONG + 2);
        `CHK("init pulse", 1, pc[4])
        `CHK("reset pulse", 1, pc[5])
        `CHK("tier oper", 4'hF, menu_tier_display)
        `CHK("port kept", 3'h5, baud1)
        `CHK("defaults applied", 1'b0, pending_defaults)
        $display("t_tiers done");
    endtask : t_tiers
    task automatic t_cmds();
        press(5'h02, LONG + 2);
        `CHK("reg start", 1, pc[0])
        `CHK("lamp blink", 2'h2, reg_lamp)
        reg_ok <= 1'b1;
        reg_done <= 1'b1;
        tick(1);
        reg_done <= 1'b0;
        tick(2);
        `CHK("lamp lit", 2'h1, reg_lamp)
        adc_err <= 1'b1;
        press(5'h02, LONG + 2);
        adc_err <= 1'b0;
        auto_scroll <= 1'b1;
        press(5'h02, LONG + 2);
        `CHK("start refused", 1, pc[0])
        auto_scroll <= 1'b0;
        reg_active <= 1'b1;
        press(5'h02, LONG + 2);
        `CHK("reg cancel", 1, pc[1])
        `CHK("lamp off", 2'h0, reg_lamp)
        reg_active <= 1'b0;
        // Aux hold written out so the blink can be seen mid-hold
        keys <= 5'h04;
        tick(5);
        `CHK("hold blink", 1'b1, fast_blink)
        tick(LONG - 3);
        keys <= 5'h00;
        tick(4);
        `CHK("alarm release", 1, pc[2])
        `CHK("alarm lamp", 1, pc[3])
        $display("t_cmds done");
    endtask : t_cmds
    task automatic t_resets();
        sw_write(2'h0, 8'h85);
        tick(100);
        `CHK("sw reset", 2, pc[5])
        op_stopped <= 1'b1;
        press(5'h01, SHORT + 2);
        `CHK("stopped hold", 3, pc[5])
        $display("t_resets done");
    endtask : t_resets
    task automatic close_out();
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        tick(20);
        sys_rst <= 1'b0;
        tick(3);
        t_defaults();
        t_link();
        t_tiers();
        t_cmds();
        t_resets();
        close_out();
    end
endmodule : testbench

// ### core/pcls_dev.sv
// Device end: key-driven menu tiers, key commands, port settings, reply gating.
// Assumes keys are debounced and synchronous to mclk.
//
// Summary of operation
// - Six bit rates per port, default 115.2k
// - Parity none or even, even by default
// - Reply waits programmable 0-99 ms, default 20
// - Station from switches 01-99, latched at power-up
// - One station number shared by both ports
// - Characters always eight data bits; data_bits reads 0 until the first clock after reset
// - One stop bit with parity, else two
// - Tier key 3 s enters initial tier
// - Short tier press steps initial, port1, port2
// - Tier key 1 s in port tier returns
// - Tier display shows port number 1 or 2
// - Reference key 3 s starts baseline registration
// - Registration only without converter error, allowed tiers
// - Reference hold 3 s cancels registration, lamp off
// - Aux key 3 s releases all alarm latches
// - Mode plus aux 3 s initializes, resets
// - Initialization spares port settings and logs
// - Internal reset: power, software command, stopped hold
// - Initialized values apply after the reset
// - Host clears errors before registration commands
// - Only matching station frames get replies
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pcls_dev
    import pcls_pkg::*;
#(
    parameter int HOLD_LONG_CYC  = HOLD_LONG_MS * MS_TICK_CYC,
    parameter int HOLD_SHORT_CYC = HOLD_SHORT_MS * MS_TICK_CYC,
    parameter int MS_CYC         = MS_TICK_CYC
)
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    pcls_if.dev              lnk,
    input  wire logic        tier_key,
    input  wire logic        ref_key,
    input  wire logic        aux_command_key,
    input  wire logic        mode_key,
    input  wire logic        up_key,
    input  wire logic [6:0]  station_sw,
    input  wire logic        port_sel,
    input  wire logic        adc_err,
    input  wire logic        auto_scroll,
    input  wire logic        op_stopped,
    input  wire logic        reg_done,
    input  wire logic        reg_ok,
    input  wire logic        reg_active,
    output logic      [3:0]  menu_tier_display,
    output logic             fast_blink,
    output logic             reg_start,
    output logic             reg_cancel,
    output logic             alarm_release,
    output logic             alarm_lamp_off,
    output logic             param_init,
    output logic             por_pulse,
    output logic      [1:0]  reg_lamp,
    output logic      [2:0]  baud1,
    output logic      [2:0]  baud2,
    output logic             parity1,
    output logic             parity2,
    output logic      [1:0]  stop_bits1,
    output logic      [1:0]  stop_bits2,
    output logic      [3:0]  data_bits,
    output logic      [6:0]  station,
    output logic             pending_defaults
);
    pcls_tier_e tier;
    logic [31:0] tier_cnt, cmd_cnt;
    logic        tier_q;
    logic        cmd_fired;
    logic [6:0]  wait1, wait2;
    logic        stn_taken;
    logic [16:0] ms_cnt;
    logic [6:0]  rsp_wait;
    logic        rsp_busy;
    logic        rsp_port;

    wire tier_rel   = tier_q && !tier_key;
    wire long_hold  = tier_cnt >= 32'(HOLD_LONG_CYC);
    wire short_hold = tier_cnt >= 32'(HOLD_SHORT_CYC);
    wire in_port    = tier == PCLS_T_PORT1 || tier == PCLS_T_PORT2;
    wire in_setup   = tier == PCLS_T_INIT || in_port;
    wire in_run     = tier == PCLS_T_OPER || tier == PCLS_T_ADJ;
    wire init_combo = mode_key && aux_command_key && in_setup;
    wire any_cmd    = ref_key || aux_command_key || init_combo;
    wire cmd_due    = cmd_cnt == 32'(HOLD_LONG_CYC) && !cmd_fired;
    wire reg_ok_ctx = !adc_err && ((tier == PCLS_T_OPER && !auto_scroll)
                                   || tier == PCLS_T_ADJ);
    wire sw_rst_hit = lnk.cmd_valid && lnk.cmd_station == station && lnk.cmd_sw_reset;

    // Tier key hold timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tier_cnt <= 32'h0000_0000;
            tier_q   <= 1'b0;
        end else begin
            tier_q   <= tier_key;
            tier_cnt <= tier_key ? (long_hold ? tier_cnt : tier_cnt + 32'h0000_0001)
                                 : 32'h0000_0000;
        end
    end

    // Menu tier machine
    always_ff @(posedge mclk) begin
        if (sys_rst || por_pulse) tier <= PCLS_T_OPER;
        else begin
            case (tier)
                PCLS_T_OPER, PCLS_T_ADJ: begin
                    if (tier_key && long_hold) tier <= PCLS_T_INIT;
                    else if (mode_key && !tier_key) tier <= PCLS_T_ADJ;
                end
                PCLS_T_INIT:  if (tier_rel && !short_hold) tier <= PCLS_T_PORT1;
                PCLS_T_PORT1: begin
                    if (tier_key && short_hold) tier <= PCLS_T_OPER;
                    else if (tier_rel) tier <= PCLS_T_PORT2;
                end
                PCLS_T_PORT2: if (tier_key && short_hold) tier <= PCLS_T_OPER;
                default: tier <= PCLS_T_OPER;
            endcase
        end
    end

    // Tier digit: port tiers show 1 or 2
    always_ff @(posedge mclk) begin
        if (sys_rst) menu_tier_display <= 4'h0;
        else begin
            case (tier)
                PCLS_T_PORT1: menu_tier_display <= 4'h1;
                PCLS_T_PORT2: menu_tier_display <= 4'h2;
                PCLS_T_INIT:  menu_tier_display <= 4'h0;
                default:      menu_tier_display <= 4'hF;  // Blank
            endcase
        end
    end

    // Command key hold timer; a command fires once per hold
    always_ff @(posedge mclk) begin
        if (sys_rst || !any_cmd) begin
            cmd_cnt   <= 32'h0000_0000;
            cmd_fired <= 1'b0;
        end else begin
            if (!cmd_fired && cmd_cnt < 32'(HOLD_LONG_CYC)) cmd_cnt <= cmd_cnt + 32'h0000_0001;
            if (cmd_due) cmd_fired <= 1'b1;
        end
    end

    // Fast blink while an accepted hold runs
    always_ff @(posedge mclk) begin
        if (sys_rst) fast_blink <= 1'b0;
        else fast_blink <= !cmd_fired && ((ref_key && reg_ok_ctx)
                           || (aux_command_key && !mode_key && in_run) || init_combo);
    end

    // Key command pulses
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_start     <= 1'b0;
            reg_cancel    <= 1'b0;
            alarm_release <= 1'b0;
            param_init    <= 1'b0;
        end else begin
            reg_start     <= cmd_due && ref_key && reg_ok_ctx && !reg_active;
            reg_cancel    <= cmd_due && ref_key && reg_ok_ctx && reg_active;
            alarm_release <= cmd_due && aux_command_key && !mode_key && in_run;
            param_init    <= cmd_due && init_combo;
        end
    end

    // Lamps
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            alarm_lamp_off <= 1'b0;
            reg_lamp       <= 2'h0;
        end else begin
            alarm_lamp_off <= alarm_release;
            if (reg_start) reg_lamp <= 2'h2;                     // Blink
            else if (reg_cancel) reg_lamp <= 2'h0;
            else if (reg_done) reg_lamp <= reg_ok ? 2'h1 : 2'h0;
        end
    end

    // Internal power-on reset sources
    always_ff @(posedge mclk) begin
        if (sys_rst) por_pulse <= 1'b0;
        else por_pulse <= param_init || sw_rst_hit
                       || (op_stopped && tier_key && tier_cnt == 32'(HOLD_SHORT_CYC));
    end

    // Defaults wait for the following reset
    always_ff @(posedge mclk) begin
        // A new initialization beats a reset landing in the same cycle
        if (sys_rst) pending_defaults <= 1'b0;
        else if (param_init) pending_defaults <= 1'b1;
        else if (por_pulse) pending_defaults <= 1'b0;
    end

    // Port settings; initialization leaves them alone
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            baud1   <= BAUD_DEF;
            baud2   <= BAUD_DEF;
            parity1 <= PARITY_DEF;
            parity2 <= PARITY_DEF;
            wait1   <= WAIT_DEF_MS;
            wait2   <= WAIT_DEF_MS;
        end else if (up_key && in_port) begin
            // Edit the visible port: rate, parity or wait by port_sel/mode
            if (tier == PCLS_T_PORT1) begin
                if (mode_key) parity1 <= !parity1;
                else if (port_sel) wait1 <= (wait1 == 7'(WAIT_MAX_MS)) ? 7'h00 : wait1 + 7'h01;
                else baud1 <= (baud1 == PCLS_BR_230K4) ? PCLS_BR_9K6 : baud1 + 3'h1;
            end else begin
                if (mode_key) parity2 <= !parity2;
                else if (port_sel) wait2 <= (wait2 == 7'(WAIT_MAX_MS)) ? 7'h00 : wait2 + 7'h01;
                else baud2 <= (baud2 == PCLS_BR_230K4) ? PCLS_BR_9K6 : baud2 + 3'h1;
            end
        end
    end

    // Framing: data bits 0 in reset, then fixed at 8; stop bits follow parity
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stop_bits1 <= 2'h1;
            stop_bits2 <= 2'h1;
            data_bits  <= 4'h0;
        end else begin
            stop_bits1 <= pcls_stop_bits(parity1);
            stop_bits2 <= pcls_stop_bits(parity2);
            data_bits  <= 4'(DATA_BITS);
        end
    end

    // Station caught once after each power-on; later switch moves ignored
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            station   <= STN_MIN;
            stn_taken <= 1'b0;
        end else if (!stn_taken) begin
            stn_taken <= 1'b1;
            if (station_sw >= STN_MIN && station_sw <= STN_MAX) station <= station_sw;
        end
    end

    // Reply timer: matching frames only, one station for both ports
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rsp_busy        <= 1'b0;
            rsp_wait        <= 7'h00;
            ms_cnt          <= 17'h0_0000;
            rsp_port        <= 1'b0;
            lnk.rsp_valid   <= 1'b0;
            lnk.rsp_station <= 7'h00;
        end else begin
            lnk.rsp_valid <= 1'b0;
            if (!rsp_busy && lnk.cmd_valid && lnk.cmd_station == station) begin
                rsp_busy <= 1'b1;
                rsp_wait <= port_sel ? wait2 : wait1;
                rsp_port <= port_sel;
                ms_cnt   <= 17'h0_0000;
            end else if (rsp_busy) begin
                if (rsp_wait == 7'h00) begin
                    rsp_busy        <= 1'b0;
                    lnk.rsp_valid   <= 1'b1;
                    lnk.rsp_station <= station;
                end else if (ms_cnt == 17'(MS_CYC - 1)) begin
                    ms_cnt   <= 17'h0_0000;
                    rsp_wait <= rsp_wait - 7'h01;
                end else ms_cnt <= ms_cnt + 17'h0_0001;
            end
        end
    end
endmodule : pcls_dev

// ### core/pcls_host.sv
// Host end: issues frames on a plain software port, counts replies.
// Assumes the software port strobes are one cycle and never together.
`timescale 1ns/1ps
module pcls_host
    import pcls_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    pcls_if.host             lnk,
    input  wire logic [1:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata
);
    localparam logic [1:0] A_CMD = 2'h0;  // Write: bit7 reset, bits6:0 station
    localparam logic [1:0] A_RSP = 2'h1;  // Read: reply count
    localparam logic [1:0] A_STN = 2'h2;  // Read: last reply station
    logic [7:0] rsp_cnt;
    logic [6:0] last_stn;
    // One-cycle frame per command write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            lnk.cmd_valid    <= 1'b0;
            lnk.cmd_station  <= 7'h00;
            lnk.cmd_sw_reset <= 1'b0;
        end else begin
            // Reset flag is a pulse beside its frame, never left standing
            lnk.cmd_valid    <= sw_wr && sw_addr == A_CMD;
            lnk.cmd_sw_reset <= sw_wr && sw_addr == A_CMD && sw_wdata[7];
            if (sw_wr && sw_addr == A_CMD) begin
                lnk.cmd_station <= sw_wdata[6:0];
            end
        end
    end
    // Reply bookkeeping
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rsp_cnt  <= 8'h00;
            last_stn <= 7'h00;
        end else if (lnk.rsp_valid) begin
            rsp_cnt  <= rsp_cnt + 8'h01;
            last_stn <= lnk.rsp_station;
        end
    end
    // Read data one cycle later
    always_ff @(posedge mclk) begin
        if (sys_rst) sw_rdata <= 8'h00;
        else if (sw_rd) begin
            case (sw_addr)
                A_RSP:   sw_rdata <= rsp_cnt;
                A_STN:   sw_rdata <= {1'b0, last_stn};
                default: sw_rdata <= 8'h00;
            endcase
        end
    end
endmodule : pcls_host

// ### core/pcls_if.sv
// Link between the panel unit and its serial host.
// Assumes both ends share mclk.
`timescale 1ns/1ps
interface pcls_if;
    import pcls_pkg::*;
    logic        cmd_valid;   // Host frame arrives
    logic [6:0]  cmd_station;
    logic        cmd_sw_reset;
    logic        rsp_valid;   // Device reply starts
    logic [6:0]  rsp_station;
    modport dev  (input cmd_valid, cmd_station, cmd_sw_reset, output rsp_valid, rsp_station);
    modport host (output cmd_valid, cmd_station, cmd_sw_reset, input rsp_valid, rsp_station);
endinterface : pcls_if

// ### core/pcls_pkg.sv
// Package for the panel command and serial link setup unit.
// Assumes a single 125 MHz clock and synchronous active-high reset.
package pcls_pkg;
    localparam int CLK_HZ         = 125_000_000;
    localparam int MS_TICK_CYC    = CLK_HZ / 1000;          // Cycles per millisecond
    localparam int HOLD_LONG_MS   = 3000;                   // Long hold, ms
    localparam int HOLD_SHORT_MS  = 1000;                   // Short hold, ms
    localparam int WAIT_MAX_MS    = 99;
    localparam logic [6:0] WAIT_DEF_MS = 7'h14;             // 20 ms
    localparam logic [6:0] STN_MIN     = 7'h01;
    localparam logic [6:0] STN_MAX     = 7'h63;             // 99
    localparam int DATA_BITS      = 8;
    // Bit rate codes, lowest first
    typedef enum logic [2:0] {
        PCLS_BR_9K6   = 3'h0,
        PCLS_BR_19K2  = 3'h1,
        PCLS_BR_38K4  = 3'h2,
        PCLS_BR_57K6  = 3'h3,
        PCLS_BR_115K2 = 3'h4,
        PCLS_BR_230K4 = 3'h5
    } pcls_baud_e;
    localparam pcls_baud_e BAUD_DEF   = PCLS_BR_115K2;
    localparam logic       PARITY_DEF = 1'b1;                // Even
    // Menu tiers, one-hot
    typedef enum logic [4:0] {
        PCLS_T_OPER  = 5'h01,
        PCLS_T_ADJ   = 5'h02,
        PCLS_T_INIT  = 5'h04,
        PCLS_T_PORT1 = 5'h08,
        PCLS_T_PORT2 = 5'h10
    } pcls_tier_e;
    // Stop bits per character
    function automatic logic [1:0] pcls_stop_bits(input logic parity_en);
        pcls_stop_bits = parity_en ? 2'h1 : 2'h2;
    endfunction : pcls_stop_bits
endpackage : pcls_pkg
